// *** design/gpc_top.v ***
/*
 General-purpose pin control register behind an APB slave.
 Five pins, each with input state, direction and output value.
 Holds a per-pin input sampler module and the register block itself.
 Assumes pins arrive asynchronous and are sampled on mclk_i.
 Assumes one APB master, a synchronous active-low reset and one clock.
 Assumes the pad logic applies gpio_oe_o and gpio_out_o to the pins.
*/
// Function
// - Second pin level read on bit 8
// - Third pin level read on bit 12
// - Fifth pin level read on bit 20
// - Bit 5 set makes first pin output
// - Bit 9 second pin direction, read/write
// - Bit 13 third pin direction, read/write
// - Bit 6 drives first pin when output
// - Bit 10 drives second pin when output
// - Fourth pin uses bits 16, 17, 18
`timescale 1ns/1ns
`default_nettype none
`include "gpc_map.vh"

// Single-pin sampler: three flops, then an agreement stage
module gpc_pin_filter (
   input wire mclk_i,
   input wire nrst_i,
   input wire pin_i,
   output wire level_o
);

   reg stage1_ff;
   reg stage2_ff;
   reg stage3_ff;
   reg level_ff;
   reg nxt_level;

   // Keep the old level until stages two and three agree
   always @* begin
      nxt_level = level_ff;
      if (stage2_ff == stage3_ff) begin
         nxt_level = stage2_ff;
      end
   end

   // Only stage two reads stage one; stage one may be metastable
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         stage1_ff <= `GPC_RST_BIT;
         stage2_ff <= `GPC_RST_BIT;
         stage3_ff <= `GPC_RST_BIT;
         level_ff <= `GPC_RST_BIT;
      end else begin
         stage1_ff <= pin_i;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         level_ff <= nxt_level;
      end
   end

   // Costs four edges of latency, buys glitch rejection
   assign level_o = level_ff;

endmodule // gpc_pin_filter

module gpc_top (
   input wire mclk_i,
   input wire nrst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire [4:0] gpio_in_i,
   output reg [4:0] gpio_out_o,
   output reg [4:0] gpio_oe_o
);

   // Bus phase codes; the answer state mirrors pready
   localparam ST_IDLE = 1'b0;
   localparam ST_ANSWER = 1'b1;

   wire [4:0] pin_level;
   reg [4:0] dir_ff;
   reg [4:0] val_ff;
   reg state_ff;
   reg nxt_state;
   reg [31:0] rd_word;
   reg [4:0] nxt_dir;
   reg [4:0] nxt_val;
   reg [4:0] nxt_oe;
   reg [4:0] nxt_out;
   wire hit;
   wire acc;

   // First pin sampler
   gpc_pin_filter u_pin1_filter (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(gpio_in_i[0]),
      .level_o(pin_level[0])
   );

   // Second pin sampler
   gpc_pin_filter u_pin2_filter (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(gpio_in_i[1]),
      .level_o(pin_level[1])
   );

   // Third pin sampler
   gpc_pin_filter u_pin3_filter (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(gpio_in_i[2]),
      .level_o(pin_level[2])
   );

   // Fourth pin sampler
   gpc_pin_filter u_pin4_filter (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(gpio_in_i[3]),
      .level_o(pin_level[3])
   );

   // Fifth pin sampler
   gpc_pin_filter u_pin5_filter (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i(gpio_in_i[4]),
      .level_o(pin_level[4])
   );

   // Only one word is mapped; any other address answers with an error
   assign hit = (paddr_i[`GPC_ADDR_W-1:0] == `GPC_CTRL_ADDR) &&
                (paddr_i[31:`GPC_ADDR_W] == `GPC_ADDR_HI_ZERO);

   // Bus phase: one wait state, then a single answer cycle
   always @* begin
      nxt_state = ST_IDLE;
      case (state_ff)
         ST_IDLE: begin
            if (psel_i && penable_i) begin
               nxt_state = ST_ANSWER;
            end
         end
         ST_ANSWER: begin
            nxt_state = ST_IDLE;        // Master must drop penable now
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Transfer is taken only once, in the idle phase
   assign acc = (state_ff == ST_IDLE) && psel_i && penable_i;

   // Read word assembly; unused and reserved bits stay zero
   always @* begin
      rd_word = `GPC_RST_WORD;
      // First pin group
      rd_word[`GPC_P1_IN] = pin_level[0];
      rd_word[`GPC_P1_DIR] = dir_ff[0];
      rd_word[`GPC_P1_VAL] = val_ff[0];
      // Second pin group
      rd_word[`GPC_P2_IN] = pin_level[1];
      rd_word[`GPC_P2_DIR] = dir_ff[1];
      rd_word[`GPC_P2_VAL] = val_ff[1];
      // Third pin group
      rd_word[`GPC_P3_IN] = pin_level[2];
      rd_word[`GPC_P3_DIR] = dir_ff[2];
      rd_word[`GPC_P3_VAL] = val_ff[2];
      // Fourth pin group
      rd_word[`GPC_P4_IN] = pin_level[3];
      rd_word[`GPC_P4_DIR] = dir_ff[3];
      rd_word[`GPC_P4_VAL] = val_ff[3];
      // Fifth pin group
      rd_word[`GPC_P5_IN] = pin_level[4];
      rd_word[`GPC_P5_DIR] = dir_ff[4];
      rd_word[`GPC_P5_VAL] = val_ff[4];
   end

   // Write decode; reserved and input-state bits ignore writes
   always @* begin
      nxt_dir = dir_ff;
      nxt_val = val_ff;
      if (acc && pwrite_i && hit) begin
         // Direction bits, set means output
         nxt_dir[0] = pwdata_i[`GPC_P1_DIR];
         nxt_dir[1] = pwdata_i[`GPC_P2_DIR];
         nxt_dir[2] = pwdata_i[`GPC_P3_DIR];
         nxt_dir[3] = pwdata_i[`GPC_P4_DIR];
         nxt_dir[4] = pwdata_i[`GPC_P5_DIR];
         // Output value bits, stored even while the pin is an input
         nxt_val[0] = pwdata_i[`GPC_P1_VAL];
         nxt_val[1] = pwdata_i[`GPC_P2_VAL];
         nxt_val[2] = pwdata_i[`GPC_P3_VAL];
         nxt_val[3] = pwdata_i[`GPC_P4_VAL];
         nxt_val[4] = pwdata_i[`GPC_P5_VAL];
      end
   end

   // Pin drive; a value only leaves while direction selects output
   always @* begin
      nxt_oe = nxt_dir;
      nxt_out = `GPC_RST_BITS;
      nxt_out[0] = nxt_val[0] & nxt_dir[0];
      nxt_out[1] = nxt_val[1] & nxt_dir[1];
      nxt_out[2] = nxt_val[2] & nxt_dir[2];
      nxt_out[3] = nxt_val[3] & nxt_dir[3];
      nxt_out[4] = nxt_val[4] & nxt_dir[4];
   end

   // Control state and bus answer; outputs come from flops
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         dir_ff <= `GPC_RST_BITS;
         val_ff <= `GPC_RST_BITS;
         state_ff <= ST_IDLE;
         pready_o <= `GPC_RST_BIT;
         pslverr_o <= `GPC_RST_BIT;
         prdata_o <= `GPC_RST_WORD;
      end else begin
         dir_ff <= nxt_dir;
         val_ff <= nxt_val;
         state_ff <= nxt_state;
         pready_o <= acc;
         pslverr_o <= acc && !hit;
         // Read data holds until the next read; unmapped reads give zero
         if (acc && !pwrite_i) begin
            prdata_o <= hit ? rd_word : `GPC_RST_WORD;
         end
      end
   end

   // Pad controls; updated on the same edge as the control word
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         gpio_oe_o <= `GPC_RST_BITS;
         gpio_out_o <= `GPC_RST_BITS;
      end else begin
         gpio_oe_o <= nxt_oe;
         gpio_out_o <= nxt_out;
      end
   end

endmodule // gpc_top
`default_nettype wire

// *** design/gpc_map.vh ***
/*
 Register map constants for the general-purpose pin control block.
 Assumes inclusion by the design file; definitions only.
*/
`ifndef GPC_MAP_VH
`define GPC_MAP_VH

// APB word address of the pin control register
`define GPC_CTRL_ADDR 12'h000
`define GPC_ADDR_W 12
// Upper address bits that must be clear for a hit
`define GPC_ADDR_HI_ZERO 20'h00000
// Pin count
`define GPC_PINS 5
// First pin fields
`define GPC_P1_DIR 5
`define GPC_P1_VAL 6
// Second pin fields
`define GPC_P2_IN 8
`define GPC_P2_DIR 9
`define GPC_P2_VAL 10
// Third pin fields
`define GPC_P3_IN 12
`define GPC_P3_DIR 13
`define GPC_P3_VAL 14
// Fourth pin fields
`define GPC_P4_IN 16
`define GPC_P4_DIR 17
`define GPC_P4_VAL 18
// Fifth pin fields
`define GPC_P5_IN 20
`define GPC_P5_DIR 21
`define GPC_P5_VAL 22
// First pin input state position
`define GPC_P1_IN 4
// Reset values
`define GPC_RST_BITS 5'h00
`define GPC_RST_BIT 1'b0
`define GPC_RST_WORD 32'h0000_0000

`endif

// *** test/gpc_top_monitor.sv ***
/* Port checker for gpc_top.
 Assumes the bind below places it on every gpc_top. */
`timescale 1ns/1ns
`default_nettype none
module gpc_monitor (input wire logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o,
   input wire logic [31:0] paddr_i, pwdata_i, prdata_o,
   input wire logic [4:0] gpio_out_o, gpio_oe_o);
   // Completed transfers to the control word
   wire acc = psel_i & penable_i & pready_o & (paddr_i == 32'h0);
   wire w = acc & pwrite_i;
   wire r = acc & !pwrite_i;
   wire [31:0] d = pwdata_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   a_p1_dir: assert property (w |-> gpio_oe_o[0] == d[5]) else $error("p1 dir");
   a_p1_val: assert property (w |-> gpio_out_o[0] == (d[6] & d[5])) else $error("p1 val");
   a_p2_val: assert property (w |-> gpio_out_o[1] == (d[10] & d[9])) else $error("p2 val");
   a_p3_dir: assert property (w |-> gpio_oe_o[2] == d[13]) else $error("p3 dir");
   a_p4_dir: assert property (w |-> gpio_oe_o[3] == d[17]) else $error("p4 dir");
   a_rd_dir: assert property (r |-> prdata_o[9] == gpio_oe_o[1]) else $error("rd dir");
   a_rsvd_zero: assert property (r |-> (prdata_o & 32'h0008_8880) == 32'h0) else $error("rsvd");
   // Inputs must never drive a level
   a_out_gate: assert property ((gpio_out_o & ~gpio_oe_o) == 5'h0) else $error("gate");
   a_rst_clear: assert property ($rose(nrst_i) |-> gpio_oe_o == 5'h0) else $error("rst");
endmodule // gpc_monitor
bind gpc_top gpc_monitor u_mon (.*);
`default_nettype wire

// *** test/tb_top.sv ***
/* Bench for gpc_top over APB.
 Assumes the design and its map header compile first. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic mclk_i = '0, nrst_i = '0, psel_i = '0, penable_i = '0, pwrite_i = '0, pready_o, pslverr_o;
   logic [31:0] paddr_i = '0, pwdata_i = '0, prdata_o, rd;
   logic [4:0] gpio_in_i = '0, gpio_out_o, gpio_oe_o;
   logic err;
   int miscompares = 0, n_checks = 0, cyc = 0;
   gpc_top u_dut (.*);
   // Clock; the ceiling cuts a hung handshake short
   initial forever #50 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (++cyc > 900) begin
      miscompares++;
      final_report;
   end
   task chk(logic [31:0] g, e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %0t got %h want %h", $time, g, e);
      end
   endtask
   // One transfer, held until pready is seen
   task apb(logic wr, logic [31:0] a, dt);
      @(posedge mclk_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, wr, a, dt};
      @(posedge mclk_i);
      penable_i <= 1'h1;
      do @(posedge mclk_i); while (pready_o !== 1'h1);
      rd = prdata_o;
      err = pslverr_o;
      {psel_i, penable_i} <= 2'h0;
   endtask
   // Reset word, then all-ones, value-only and direction-only writes
   task t_ctrl;
      logic [31:0] pat [3] = '{32'hffff_ffff, 32'h0044_4440, 32'h0022_2220};
      logic [4:0] o;
      apb(0, 0, 0);
      chk(rd, 0);
      foreach (pat[i]) begin
         apb(1, 0, pat[i]);
         o = {pat[i][21], pat[i][17], pat[i][13], pat[i][9], pat[i][5]};
         chk({gpio_out_o, gpio_oe_o}, {o & {pat[i][22], pat[i][18], pat[i][14],
            pat[i][10], pat[i][6]}, o});
         apb(0, 0, 0);
         chk({err, rd}, {1'h0, pat[i] & 32'h0066_6660});
      end
   endtask
   // Pin levels land after the input filter settles
   task t_pins;
      gpio_in_i <= 5'h1a;
      repeat (8) @(posedge mclk_i);
      apb(0, 0, 0);
      chk(rd, 32'h0033_2320);
      gpio_in_i <= 5'h05;
      repeat (8) @(posedge mclk_i);
      apb(0, 0, 0);
      chk(rd, 32'h0022_3230);
   endtask
   // Unmapped word: error answer, write ignored, read gives zero
   task t_err;
      apb(1'h1, 32'h0000_0004, 32'hffff_ffff);
      chk({err, gpio_oe_o, gpio_out_o}, {1'h1, 5'h1f, 5'h00});
      apb(1'h0, 32'h0000_0004, 32'h0000_0000);
      chk({err, rd}, {1'h1, 32'h0000_0000});
   endtask
   // Mid-run reset clears controls; pin levels return after the filter
   task t_rst;
      apb(1'h1, 32'h0000_0000, 32'hffff_ffff);
      nrst_i <= 1'h0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'h1;
      @(posedge mclk_i);
      chk({gpio_oe_o, gpio_out_o, pready_o}, 11'h000);
      chk(prdata_o, 32'h0000_0000);
      repeat (8) @(posedge mclk_i);
      apb(1'h0, 32'h0000_0000, 32'h0000_0000);
      chk(rd, 32'h0000_1010);
   endtask
   task final_report;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      nrst_i <= 1'h1;
      t_ctrl;
      t_pins;
      t_err;
      t_rst;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
